//--- pkg/synth_test_pkg.sv
// Package with register map, field layout and reset values of the synthesizer test bank.
package synth_test_pkg;
  localparam logic [7:0] OFF_VCO_CAL   = 8'h5b;
  localparam logic [7:0] OFF_SYNTH     = 8'h5c;
  localparam logic [7:0] OFF_BLK_A     = 8'h5d;
  localparam logic [7:0] OFF_BLK_B     = 8'h5e;
  localparam logic [7:0] OFF_BLK_C     = 8'h5f;
  localparam logic [7:0] OFF_COEF_ADDR = 8'h60;
  localparam logic [7:0] OFF_COEF_VAL  = 8'h61;
  localparam logic [7:0] OFF_XTAL      = 8'h62;

  localparam int VCO_OVR_BIT   = 7;
  localparam int DITHER_BIT    = 7;
  localparam int VCO_TYPE_BIT  = 6;
  localparam int LOCK_DET_BIT  = 6;
  localparam int BUF_OVR_BIT   = 1;
  localparam int BUF_EN_BIT    = 0;
  localparam int PWR_LSB       = 5;

  localparam logic [7:0] RST_VCO_CAL   = 8'h00;
  localparam logic [7:0] RST_SYNTH     = 8'h0e;
  localparam logic [7:0] RST_BLK_A     = 8'h00;
  localparam logic [7:0] RST_BLK_B     = 8'h00;
  localparam logic [7:0] RST_BLK_C     = 8'h00;
  localparam logic [7:0] RST_COEF_ADDR = 8'h00;
  localparam logic [7:0] RST_COEF_VAL  = 8'h00;
  localparam logic [4:0] RST_XTAL      = 5'h04;
  localparam logic [7:0] MASK_BLK_A    = 8'hef;
  localparam logic [7:0] MASK_COEF_A   = 8'h0f;
  localparam logic [7:0] MASK_COEF_V   = 8'h3f;

  typedef enum logic [2:0] {
    PWR_LOW   = 3'h0,
    PWR_READY = 3'h1,
    PWR_TUNE  = 3'h3,
    PWR_TX    = 3'h2
  } power_state_e;

  typedef enum logic [1:0] {
    DSM_ORDER0 = 2'h0,
    DSM_ORDER1 = 2'h1,
    DSM_ORDER2 = 2'h2,
    DSM_MASH   = 2'h3
  } dsm_order_e;

  typedef struct packed {
    logic       ditherEn;
    logic       openLoop;
    logic       modulusSel;
    dsm_order_e order;
    logic       resetMode;
    logic       dsmReset;
  } dsm_ctrl_s;

  typedef struct packed {
    logic clkHyst;
    logic doubleBiasSelect;
    logic doubleGainSelect;
    logic bufOverride;
    logic bufEnable;
  } xtal_ctrl_s;
endpackage

//--- core/synth_test_override_regs.sv
// Synthesizer and receive-chain test and override register bank.
// Notes on behaviour
// - Without override, reading calibration field returns engine result.
// - With override set, host-written calibration value replaces engine result.
// - Bit 7 of calibration register reads the calibration done flag.
// - Synthesizer test bit 7 enables modulator dither; cleared means none.
// - VCO type bit reads zero for a basic constant-gain VCO.
// - VCO type bit reads one for single-varactor varying-gain VCO.
// - Two-bit order field selects zero, first, second order or MASH.
// - With buffer override clear, power state machine drives output buffer.
// - Buffer enable bit acts only while buffer override is set.
// - Three-bit power-state field reports low power, ready, tune, transmit.
// - Four-bit coefficient address selects the filter table entry.
// - Coefficient value reads and writes hit the addressed table entry.
// - Lock-detect enable bit drives the lock detector directly.
// - Block-enable override bits, except block A bit 4 which is masked to zero, each override one analog block enable.
// - Crystal control low five bits reset to 00100.
// - Calibration, block A and C, and coefficient value clear on reset.
`timescale 1ns/1ns
`default_nettype none
module synth_test_override_regs #(
  parameter int COEF_DEPTH = 16,
  parameter int COEF_WIDTH = 6,
  parameter bit VCO_VARACTOR = 1'b0
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   wrEn,
  input  wire logic                   rdEn,
  input  wire logic [7:0]             addr,
  input  wire logic [7:0]             wrData,
  output logic      [7:0]             rdData,
  input  wire logic [6:0]             calResult,
  input  wire logic                   calDone,
  input  wire logic [2:0]             powerState,
  input  wire logic                   smBufEnable,
  output logic      [6:0]             vcoCalOut,
  output synth_test_pkg::dsm_ctrl_s   dsmCtrl,
  output logic      [7:0]             blockOvrA,
  output logic      [7:0]             blockOvrB,
  output logic      [7:0]             blockOvrC,
  output logic                        lockDetectEn,
  output synth_test_pkg::xtal_ctrl_s  xtalCtrl,
  output logic                        xtalBufOn,
  output logic      [COEF_WIDTH*COEF_DEPTH-1:0] coefTable
);
  initial begin
    if (COEF_DEPTH != 16 || COEF_WIDTH < 1 || COEF_WIDTH > 8) begin
      $error("Coefficient table must have 16 entries of 1 to 8 bits.");
    end
  end

  logic [7:0]                 vcoCal_q, vcoCal_d;
  logic [7:0]                 synth_q, synth_d;
  logic [7:0]                 blkA_q, blkA_d;
  logic [7:0]                 blkB_q, blkB_d;
  logic [7:0]                 blkC_q, blkC_d;
  logic [3:0]                 coefAddr_q, coefAddr_d;
  logic [4:0]                 xtal_q, xtal_d;
  logic [COEF_WIDTH-1:0]      coef_q [COEF_DEPTH];
  logic [COEF_WIDTH-1:0]      coef_d [COEF_DEPTH];
  logic [7:0]                 rd_q, rd_d;
  logic [6:0]                 calOut_q, calOut_d;
  logic                       bufOn_q, bufOn_d;
  logic [7:0]                 rdMux;
  logic [7:0]                 coefRd;

  // The addressed entry, widened into the low bits; upper bits are reserved.
  always_comb begin
    coefRd = 8'h00;
    coefRd[COEF_WIDTH-1:0] = coef_q[coefAddr_q];
  end

  always_comb begin
    vcoCal_d = vcoCal_q;
    synth_d = synth_q;
    blkA_d = blkA_q;
    blkB_d = blkB_q;
    blkC_d = blkC_q;
    coefAddr_d = coefAddr_q;
    xtal_d = xtal_q;
    coef_d = coef_q;
    if (wrEn) begin
      case (addr)
        synth_test_pkg::OFF_VCO_CAL: vcoCal_d = wrData;
        synth_test_pkg::OFF_SYNTH: synth_d = wrData;
        synth_test_pkg::OFF_BLK_A: blkA_d = wrData & synth_test_pkg::MASK_BLK_A;
        synth_test_pkg::OFF_BLK_B: blkB_d = wrData;
        synth_test_pkg::OFF_BLK_C: blkC_d = wrData;
        synth_test_pkg::OFF_COEF_ADDR: coefAddr_d = wrData[3:0];
        synth_test_pkg::OFF_COEF_VAL: coef_d[coefAddr_q] = wrData[COEF_WIDTH-1:0];
        synth_test_pkg::OFF_XTAL: xtal_d = wrData[4:0];
        default: vcoCal_d = vcoCal_q;
      endcase
    end
    if (rst) begin
      vcoCal_d = synth_test_pkg::RST_VCO_CAL;
      synth_d = synth_test_pkg::RST_SYNTH;
      blkA_d = synth_test_pkg::RST_BLK_A;
      blkB_d = synth_test_pkg::RST_BLK_B;
      blkC_d = synth_test_pkg::RST_BLK_C;
      coefAddr_d = synth_test_pkg::RST_COEF_ADDR[3:0];
      xtal_d = synth_test_pkg::RST_XTAL;
      for (int i = 0; i < COEF_DEPTH; i++) begin
        coef_d[i] = '0;
      end
    end
  end

  always_comb begin
    case (addr)
      synth_test_pkg::OFF_VCO_CAL: begin
        // Done flag replaces the override bit on read; the override stays stored.
        rdMux = {calDone, vcoCal_q[synth_test_pkg::VCO_OVR_BIT] ? vcoCal_q[6:0]
                                                              : calResult};
      end
      synth_test_pkg::OFF_SYNTH: begin
        rdMux = synth_q;
        rdMux[synth_test_pkg::VCO_TYPE_BIT] = VCO_VARACTOR;
      end
      synth_test_pkg::OFF_BLK_A: rdMux = blkA_q;
      synth_test_pkg::OFF_BLK_B: rdMux = blkB_q;
      synth_test_pkg::OFF_BLK_C: rdMux = blkC_q;
      synth_test_pkg::OFF_COEF_ADDR: rdMux = {4'h0, coefAddr_q};
      synth_test_pkg::OFF_COEF_VAL: rdMux = coefRd;
      synth_test_pkg::OFF_XTAL: rdMux = {powerState, xtal_q};
      default: rdMux = 8'h00;
    endcase
  end

  always_comb begin
    rd_d = rd_q;
    if (rdEn) begin
      rd_d = rdMux;
    end
    calOut_d = vcoCal_q[synth_test_pkg::VCO_OVR_BIT] ? vcoCal_q[6:0] : calResult;
    bufOn_d = xtal_q[synth_test_pkg::BUF_OVR_BIT] ? xtal_q[synth_test_pkg::BUF_EN_BIT]
                                                  : smBufEnable;
    if (rst) begin
      rd_d = 8'h00;
      calOut_d = 7'h00;
      bufOn_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    vcoCal_q <= vcoCal_d;
    synth_q <= synth_d;
    blkA_q <= blkA_d;
    blkB_q <= blkB_d;
    blkC_q <= blkC_d;
    coefAddr_q <= coefAddr_d;
    xtal_q <= xtal_d;
    coef_q <= coef_d;
    rd_q <= rd_d;
    calOut_q <= calOut_d;
    bufOn_q <= bufOn_d;
  end

  assign rdData = rd_q;
  assign vcoCalOut = calOut_q;
  assign dsmCtrl = {synth_q[synth_test_pkg::DITHER_BIT], synth_q[5:0]};
  assign blockOvrA = blkA_q;
  assign blockOvrB = blkB_q;
  assign blockOvrC = blkC_q;
  assign lockDetectEn = blkB_q[synth_test_pkg::LOCK_DET_BIT];
  assign xtalCtrl = xtal_q;
  assign xtalBufOn = bufOn_q;

  for (genvar g = 0; g < COEF_DEPTH; g++) begin : gCoef
    assign coefTable[g*COEF_WIDTH +: COEF_WIDTH] = coef_q[g];
  end
endmodule
`default_nettype wire

//--- bench/synth_test_properties.sv
// Port assertions for the synthesizer test register bank.
`timescale 1ns/1ns
`default_nettype none
module synth_test_properties #(
  parameter bit VCO_VARACTOR = 1'b0
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       wrEn,
  input wire logic                       rdEn,
  input wire logic [7:0]                 addr,
  input wire logic [7:0]                 wrData,
  input wire logic [7:0]                 rdData,
  input wire logic [6:0]                 calResult,
  input wire logic                       calDone,
  input wire logic [2:0]                 powerState,
  input wire logic                       smBufEnable,
  input wire logic [6:0]                 vcoCalOut,
  input wire synth_test_pkg::dsm_ctrl_s  dsmCtrl,
  input wire logic [7:0]                 blockOvrB,
  input wire logic                       lockDetectEn,
  input wire synth_test_pkg::xtal_ctrl_s xtalCtrl,
  input wire logic                       xtalBufOn
);
  // The override bit reads back as the done flag, so it is mirrored here.
  logic ovrQ;
  always_ff @(posedge clk) begin
    if (rst) begin
      ovrQ <= 1'b0;
    end else if (wrEn && addr == 8'h5b) begin
      ovrQ <= wrData[7];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_done_flag: assert property (rdEn && addr == 8'h5b |=> rdData[7] == $past(calDone))
    else $error("done flag wrong");
  a_cal_engine: assert property (!ovrQ && !(wrEn && addr == 8'h5b) |=> vcoCalOut == $past(calResult))
    else $error("engine result not passed");
  // The output follows the stored register, so it lags the write by two edges.
  a_cal_override: assert property (wrEn && addr == 8'h5b && wrData[7] |=> ##1 vcoCalOut == $past(wrData[6:0], 2))
    else $error("override value not used");
  a_dither_bit: assert property (wrEn && addr == 8'h5c |=> dsmCtrl.ditherEn == $past(wrData[7]))
    else $error("dither enable wrong");
  a_vco_type: assert property (rdEn && addr == 8'h5c |=> rdData[6] == VCO_VARACTOR)
    else $error("vco type wrong");
  a_buf_state: assert property (!xtalCtrl.bufOverride && !wrEn |=> xtalBufOn == $past(smBufEnable))
    else $error("buffer not from state machine");
  a_buf_direct: assert property (xtalCtrl.bufOverride && !wrEn |=> xtalBufOn == $past(xtalCtrl.bufEnable))
    else $error("buffer not from enable bit");
  a_power_read: assert property (rdEn && addr == 8'h62 |=> rdData[7:5] == $past(powerState))
    else $error("power state field wrong");
  a_lock_direct: assert property (lockDetectEn == blockOvrB[6])
    else $error("lock detect not direct");
  a_unmapped_zero: assert property (rdEn && (addr < 8'h5b || addr > 8'h62) |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  c_override: cover property (wrEn && addr == 8'h5b && wrData[7]);
  c_buf_ovr: cover property (xtalCtrl.bufOverride);
  c_coef_rd: cover property (rdEn && addr == 8'h61);
endmodule
`default_nettype wire

//--- bench/tb.sv
// Directed testbench for the synthesizer test register bank.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                       clk, rst, wrEn, rdEn, calDone, smBufEnable, lockDetectEn, xtalBufOn;
  logic [7:0]                 addr, wrData, rdData, blockOvrA, blockOvrB, blockOvrC;
  logic [6:0]                 calResult, vcoCalOut;
  logic [2:0]                 powerState;
  logic [95:0]                coefTable;
  synth_test_pkg::dsm_ctrl_s  dsmCtrl;
  synth_test_pkg::xtal_ctrl_s xtalCtrl;
  int                         miscompares = 0, nTests = 0, cycles = 0;
  localparam logic [2:0] PST [4] = '{3'h0, 3'h1, 3'h3, 3'h2};
  synth_test_override_regs dut (.clk, .rst, .wrEn, .rdEn, .addr, .wrData, .rdData, .calResult,
    .calDone, .powerState, .smBufEnable, .vcoCalOut, .dsmCtrl, .blockOvrA, .blockOvrB,
    .blockOvrC, .lockDetectEn, .xtalCtrl, .xtalBufOn, .coefTable);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
    #1;
  endtask
  // Looking one edge late is safe because read data holds until the next read.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    @(posedge clk);
    #1;
    chk(rdData, e);
  endtask
  task automatic bufchk(input logic e);
    @(posedge clk);
    #1;
    chk({7'h0, xtalBufOn}, {7'h0, e});
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    rst = 1'b1; wrEn = 1'b0; rdEn = 1'b0; addr = 8'h00; wrData = 8'h00;
    calResult = 7'h15; calDone = 1'b0; powerState = 3'h1; smBufEnable = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h5b, 8'h15);
    rd(8'h62, 8'h24);
    chk({3'h0, xtalCtrl}, 8'h04);
    rd(8'h61, 8'h00);
    calDone <= 1'b1;
    wr(8'h5b, 8'haa);
    rd(8'h5b, 8'haa);
    chk({1'b0, vcoCalOut}, 8'h2a);
    for (int i = 0; i < 4; i++) begin
      wr(8'h5c, {i[0], 3'h7, i[1:0], 2'h1});
      chk({6'h0, dsmCtrl.order}, 8'(i));
      chk({7'h0, dsmCtrl.ditherEn}, {7'h0, i[0]});
      rd(8'h5c, {i[0], 3'h3, i[1:0], 2'h1});
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h60, 8'(i));
      wr(8'h61, 8'(i * 3));
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h60, 8'(i));
      rd(8'h61, 8'(i * 3));
      chk({2'h0, coefTable[6 * i +: 6]}, 8'(i * 3));
    end
    foreach (PST[i]) begin
      powerState <= PST[i];
      rd(8'h62, {PST[i], 5'h04});
    end
    wr(8'h62, 8'h07);
    bufchk(1'b1);
    smBufEnable <= 1'b1;
    wr(8'h62, 8'h06);
    bufchk(1'b0);
    wr(8'h62, 8'h04);
    bufchk(1'b1);
    wr(8'h5d, 8'hff);
    rd(8'h5d, 8'hef);
    chk(blockOvrA, 8'hef);
    wr(8'h5e, 8'h40);
    chk({7'h0, lockDetectEn}, 8'h01);
    wr(8'h5f, 8'ha5);
    chk(blockOvrC, 8'ha5);
    wr(8'h63, 8'hff);
    rd(8'h63, 8'h00);
    wr(8'h5b, 8'h00);
    calResult <= 7'h5a;
    rd(8'h5b, 8'hda);
    end_sim();
  end
endmodule
bind synth_test_override_regs synth_test_properties #(.VCO_VARACTOR(VCO_VARACTOR)) props (.clk,
  .rst, .wrEn, .rdEn, .addr, .wrData, .rdData, .calResult, .calDone, .powerState, .smBufEnable,
  .vcoCalOut, .dsmCtrl, .blockOvrB, .lockDetectEn, .xtalCtrl, .xtalBufOn);
`default_nettype wire
